// File: inc/cmc_pkg.sv
// Package for the core mode control register block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package cmc_pkg;
   // Register byte offsets on the bus.
   localparam logic [3:0]  CMC_OFF_MODE   = 4'h0;
   localparam logic [3:0]  CMC_OFF_STATUS = 4'h4;
   localparam int          CMC_ADDR_W     = 4;
   // Field positions in the mode register.
   localparam int          CMC_BIT_ARB    = 13;
   localparam int          CMC_BIT_PRIO_OFF = 14;
   localparam int          CMC_BIT_TRACE  = 15;
   localparam int          CMC_BIT_PATCH  = 23;
   localparam int          CMC_BOOT_LSB   = 0;
   // Writable control bits and reset value of the mode register.
   localparam logic [23:0] CMC_CTRL_MASK  = 24'h80E000;
   localparam logic [23:0] CMC_MODE_RST   = 24'h000000;
   localparam int          CMC_ADDR_OUT_W = 18;
endpackage : cmc_pkg

// File: verification/test_core_mode_control_bits.sv
// Testbench for the core mode control register block, driven over Avalon-MM.
// Assumes cmc_pkg and cmc_mode_ctrl are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("FAIL t=%0t got %h exp %h", $time, (a), (e)); end end
module test_core_mode_control_bits
   import cmc_pkg::*;
();
   logic                      clk = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0;
   logic [CMC_ADDR_W-1:0]     address = '0;
   logic [31:0]               writedata = '0, readdata, rd;
   logic [3:0]                bootPins = 4'hA, byteEn = 4'hF;
   logic [2:0]                attrMatch = 3'h0, addr_attr_outputs;
   logic                      extBusNeeded = 1'b0, intAccess = 1'b0, romHitPatch = 1'b0;
   logic                      waitrequest, async_arb_en, traceValid, fetchFromCache;
   logic [1:0]                response, rsp;
   logic [CMC_ADDR_OUT_W-1:0] intAddr = '0, traceAddr;
   int                        mismatches = 0, n_checks = 0;
   // The device under test; byte lanes are chosen per access.
   cmc_mode_ctrl uut (.clk, .rst_n, .address, .read, .write, .writedata, .byteenable(byteEn),
      .readdata, .waitrequest, .response, .boot_pin_0(bootPins[0]), .boot_pin_1(bootPins[1]),
      .boot_pin_2(bootPins[2]), .boot_pin_3(bootPins[3]), .attrMatch, .extBusNeeded,
      .intAccess, .intAddr, .romHitPatch, .async_arb_en, .addr_attr_outputs, .traceValid,
      .traceAddr, .fetchFromCache);
   // Free-running 25 MHz clock.
   initial begin
      forever #20 clk = ~clk;
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : print_verdict
   // One bus access on all byte lanes.
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      bus_be(w, a, d, 4'hF);
   endtask : bus
   // One bus access with chosen lanes, held until waitrequest is sampled low.
   task automatic bus_be(input logic w, input logic [3:0] a, input logic [31:0] d,
                         input logic [3:0] be);
      int i;
      i = 0;
      @(posedge clk);
      address <= a;
      writedata <= d;
      byteEn <= be;
      read <= !w;
      write <= w;
      do begin
         @(posedge clk);
         i++;
      end while (waitrequest !== 1'b0 && i < 50);
      if (i >= 50) begin
         mismatches++;
         print_verdict();
      end
      rd = readdata;
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus_be
   // Reads a register and compares data and an OK response.
   task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      `CHK({rsp, rd}, {2'h0, e})
   endtask : rdchk
   // Lets registered outputs follow new inputs.
   task automatic settle;
      repeat (2) @(posedge clk);
   endtask : settle
   // Synchronous reset held for six cycles.
   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
   endtask : do_reset
   // Reset clears the control bits and latches the boot pins.
   task automatic t_reset;
      do_reset();
      rdchk(CMC_OFF_MODE, 32'h0000000A);
      `CHK({async_arb_en, traceValid, fetchFromCache}, 3'h0)
   endtask : t_reset
   // All ones written: only control bits stick, reserved bits read zero.
   task automatic t_regs;
      bus(1'b1, CMC_OFF_MODE, 32'hFFFFFFFF);
      rdchk(CMC_OFF_MODE, 32'h0080E00A);
      `CHK(async_arb_en, 1'b1)
      bus(1'b1, CMC_OFF_MODE, 32'h0);
      rdchk(CMC_OFF_MODE, 32'h0000000A);
      `CHK(async_arb_en, 1'b0)
      bus_be(1'b1, CMC_OFF_MODE, 32'hFFFFFFFF, 4'h4);
      rdchk(CMC_OFF_MODE, 32'h0080000A);
   endtask : t_regs
   // Priority keeps one attribute line; priority off lets all matches through.
   task automatic t_attr;
      attrMatch <= 3'b110;
      settle();
      `CHK(addr_attr_outputs, 3'b010)
      bus(1'b1, CMC_OFF_MODE, 32'h4000);
      settle();
      `CHK(addr_attr_outputs, 3'b110)
   endtask : t_attr
   // Internal addresses appear only when tracing is on and the bus is free.
   task automatic t_trace;
      intAccess <= 1'b1;
      intAddr <= 18'h2A5A5;
      settle();
      `CHK(traceValid, 1'b0)
      bus(1'b1, CMC_OFF_MODE, 32'h8000);
      settle();
      `CHK({traceValid, traceAddr}, {1'b1, 18'h2A5A5})
      extBusNeeded <= 1'b1;
      settle();
      `CHK(traceValid, 1'b0)
      rdchk(CMC_OFF_STATUS, 32'h00000058);
   endtask : t_trace
   // Patched fetches come from the cache until a reset clears the bit.
   task automatic t_patch;
      romHitPatch <= 1'b1;
      settle();
      `CHK(fetchFromCache, 1'b0)
      bus(1'b1, CMC_OFF_MODE, 32'h800000);
      settle();
      `CHK(fetchFromCache, 1'b1)
      bootPins <= 4'h5;
      do_reset();
      rdchk(CMC_OFF_MODE, 32'h00000005);
      `CHK(fetchFromCache, 1'b0)
   endtask : t_patch
   // An unmapped place refuses the write and answers 3; moved pins leave boot bits alone.
   task automatic t_unmapped;
      bootPins <= 4'h3;
      bus(1'b1, 4'h8, 32'hFFFFFFFF);
      `CHK(rsp, 2'h3)
      bus(1'b0, 4'h8, 32'h0);
      `CHK({rsp, rd}, {2'h3, 32'h0})
      rdchk(CMC_OFF_MODE, 32'h00000005);
   endtask : t_unmapped
   // Main sequence.
   initial begin
      t_reset();
      t_regs();
      t_attr();
      t_trace();
      t_patch();
      t_unmapped();
      print_verdict();
   end
endmodule : test_core_mode_control_bits
`default_nettype wire

// File: verilog/cmc_mode_ctrl.sv
// Core mode control register with its steering of bus, attribute and fetch paths.
// Assumes one 25 MHz clock, synchronous active-low reset, boot pins from outside.
//
// Operation
// R1: Bit 13 set selects asynchronous bus arbitration, clear selects normal arbitration.
// R2: Reset clears the asynchronous arbitration bit.
// R3: Bit 14 set drops attribute priority so several attribute outputs may assert together.
// R4: Reset clears the attribute priority-off bit.
// R5: Bit 15 set shows internal fetch and move addresses on the idle address bus.
// R6: Reset clears the address trace bit.
// R7: Bit 23 set serves patched ROM locations from the instruction cache instead of the ROM.
// R8: Reset clears the ROM patch bit.
// R9: Reserved bits read as zero and ignore writes.
// R10: Software enables cache, sets the patch bit, unlocks eight sectors, then locks and loads.
// R11: The four boot pins are sampled during reset and held as the operating mode bits.
// R12: Control bits are read and written by software and steer later bus and fetch operations.
`timescale 1ns/1ps
`default_nettype none
module cmc_mode_ctrl
   import cmc_pkg::*;
(
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [CMC_ADDR_W-1:0]     address,
   input  wire logic                      read,
   input  wire logic                      write,
   input  wire logic [31:0]               writedata,
   input  wire logic [3:0]                byteenable,
   output logic      [31:0]               readdata,
   output logic                           waitrequest,
   output logic      [1:0]                response,
   input  wire logic                      boot_pin_0,
   input  wire logic                      boot_pin_1,
   input  wire logic                      boot_pin_2,
   input  wire logic                      boot_pin_3,
   input  wire logic [2:0]                attrMatch,
   input  wire logic                      extBusNeeded,
   input  wire logic                      intAccess,
   input  wire logic [CMC_ADDR_OUT_W-1:0] intAddr,
   input  wire logic                      romHitPatch,
   output logic                           async_arb_en,
   output logic      [2:0]                addr_attr_outputs,
   output logic                           traceValid,
   output logic      [CMC_ADDR_OUT_W-1:0] traceAddr,
   output logic                           fetchFromCache
);

   logic [23:0] modeReg;
   logic [3:0]  bootSync1;
   logic [3:0]  bootSync2;
   logic        accDone;
   logic [2:0]  next_attr;
   logic        accTake;

   // Boot pins pass two flip-flops before use.
   always_ff @(posedge clk) begin
      bootSync1 <= {boot_pin_3, boot_pin_2, boot_pin_1, boot_pin_0};
      bootSync2 <= bootSync1;
   end

   // A request is taken when it meets an idle slave with no access in flight.
   assign accTake = (read | write) & waitrequest & ~accDone;

   // Accesses answer in two cycles: waitrequest falls for one cycle after the request.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         accDone     <= 1'b0;
         waitrequest <= 1'b1;
      end else begin
         accDone     <= accTake;
         waitrequest <= ~accTake;
      end
   end

   // Mode register: boot bits caught while in reset, control bits written by software.
   // A write lands at the completing edge, where the master sees waitrequest low.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         modeReg <= CMC_MODE_RST; // R2 R4 R6 R8
         modeReg[CMC_BOOT_LSB +: 4] <= bootSync2; // R11
      end else if (write && !waitrequest && address == CMC_OFF_MODE) begin
         if (byteenable[1]) begin
            modeReg[CMC_BIT_TRACE:CMC_BIT_ARB] <= writedata[CMC_BIT_TRACE:CMC_BIT_ARB]; // R12
         end
         if (byteenable[2]) begin
            modeReg[CMC_BIT_PATCH] <= writedata[CMC_BIT_PATCH]; // R12
         end
      end
   end

   // Read data and response; reserved bits and unmapped offsets read zero.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         readdata <= 32'h00000000;
         response <= 2'h0;
      end else if (accTake) begin
         response <= (address == CMC_OFF_MODE || address == CMC_OFF_STATUS) ? 2'h0 : 2'h3;
         if (read && address == CMC_OFF_MODE) begin
            readdata <= {8'h00, modeReg & (CMC_CTRL_MASK | 24'h00000F)}; // R9
         end else if (read && address == CMC_OFF_STATUS) begin
            readdata <= {25'h0, extBusNeeded, romHitPatch, attrMatch, 2'h0};
         end else begin
            readdata <= 32'h00000000;
         end
      end
   end

   // Attribute outputs: priority picks lowest matching line unless disabled.
   always_comb begin
      if (modeReg[CMC_BIT_PRIO_OFF]) begin
         next_attr = attrMatch; // R3
      end else begin
         next_attr = attrMatch & (~attrMatch + 3'h1); // R3
      end
   end

   // Steering outputs registered from the mode bits.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         async_arb_en      <= 1'b0;
         addr_attr_outputs <= 3'h0;
         traceValid        <= 1'b0;
         traceAddr         <= '0;
         fetchFromCache    <= 1'b0;
      end else begin
         async_arb_en      <= modeReg[CMC_BIT_ARB]; // R1
         addr_attr_outputs <= next_attr;
         traceValid        <= modeReg[CMC_BIT_TRACE] & intAccess & ~extBusNeeded; // R5
         if (modeReg[CMC_BIT_TRACE] && intAccess && !extBusNeeded) begin
            traceAddr <= intAddr; // R5
         end
         fetchFromCache    <= modeReg[CMC_BIT_PATCH] & romHitPatch; // R7
      end
   end

   // Request and completion steps of the register bus, shared by the bus checks below.
   sequence s_req;
      accTake;
   endsequence
   sequence s_modeWrDone;
      !waitrequest && write && address == CMC_OFF_MODE;
   endsequence
   sequence s_modeRead;
      accTake && read && address == CMC_OFF_MODE;
   endsequence

   // The arbitration output follows the mode bit one cycle later.
   property p_arb;
      @(posedge clk) disable iff (!rst_n) ##1 async_arb_en == $past(modeReg[CMC_BIT_ARB]);
   endproperty
   a_arb: assert property (p_arb) else $error("arb mode mismatch"); // R1

   // Every control bit is clear in the cycle after a reset edge.
   property p_rst;
      @(posedge clk) !rst_n |=> modeReg[23:13] == 11'h000;
   endproperty
   a_rst: assert property (p_rst) else $error("control bits not cleared"); // R2 R4 R6 R8

   // The steering outputs and the bus answer are quiet after a reset edge.
   property p_rstOut;
      @(posedge clk) !rst_n |=> !async_arb_en && addr_attr_outputs == 3'h0 && !traceValid
         && !fetchFromCache && waitrequest;
   endproperty
   a_rstOut: assert property (p_rstOut) else $error("outputs not quiet after reset"); // R2

   // The boot bits hold what the synchronised pins showed at the last reset edge.
   property p_bootLatch;
      @(posedge clk) !rst_n ##1 rst_n |-> modeReg[CMC_BOOT_LSB +: 4] == $past(bootSync2);
   endproperty
   a_bootLatch: assert property (p_bootLatch) else $error("boot bits not latched"); // R11

   // Outside reset the boot bits never move, whatever the pins do.
   property p_bootHold;
      @(posedge clk) disable iff (!rst_n) $past(rst_n) |-> $stable(modeReg[CMC_BOOT_LSB +: 4]);
   endproperty
   a_bootHold: assert property (p_bootHold) else $error("boot bits changed"); // R11

   // With priority on, at most one attribute line is driven.
   property p_prio;
      @(posedge clk) disable iff (!rst_n)
         !modeReg[CMC_BIT_PRIO_OFF] |=> $onehot0(addr_attr_outputs);
   endproperty
   a_prio: assert property (p_prio) else $error("priority broken"); // R3

   // With priority off, every matching attribute line is driven together.
   property p_prioOff;
      @(posedge clk) disable iff (!rst_n)
         modeReg[CMC_BIT_PRIO_OFF] |=> addr_attr_outputs == $past(attrMatch);
   endproperty
   a_prioOff: assert property (p_prioOff) else $error("attribute lines held back"); // R3

   // With tracing on, an internal access on an idle bus is shown with its address.
   property p_trace;
      @(posedge clk) disable iff (!rst_n)
         (modeReg[CMC_BIT_TRACE] && intAccess && !extBusNeeded)
            |=> traceValid && traceAddr == $past(intAddr);
   endproperty
   a_trace: assert property (p_trace) else $error("trace missing"); // R5

   // A bus needed for an external access is never used for tracing.
   property p_notrace;
      @(posedge clk) disable iff (!rst_n) extBusNeeded |=> !traceValid;
   endproperty
   a_notrace: assert property (p_notrace) else $error("trace over busy bus"); // R5

   // Without the patch bit every fetch comes from the ROM.
   property p_patch;
      @(posedge clk) disable iff (!rst_n) !modeReg[CMC_BIT_PATCH] |=> !fetchFromCache;
   endproperty
   a_patch: assert property (p_patch) else $error("patch without enable"); // R7

   // With the patch bit a patched location is served from the cache.
   property p_patchOn;
      @(posedge clk) disable iff (!rst_n)
         modeReg[CMC_BIT_PATCH] && romHitPatch |=> fetchFromCache;
   endproperty
   a_patchOn: assert property (p_patchOn) else $error("patch not served"); // R7

   // Reserved places of the mode register read as zero.
   property p_resv;
      @(posedge clk) disable iff (!rst_n)
         s_modeRead |=> readdata[31:24] == 8'h00 && readdata[22:16] == 7'h00
            && readdata[12:4] == 9'h000;
   endproperty
   a_resv: assert property (p_resv) else $error("reserved bit set"); // R9

   // Offsets outside the map answer with code 3 and zero data.
   property p_unmapped;
      @(posedge clk) disable iff (!rst_n)
         accTake && address != CMC_OFF_MODE && address != CMC_OFF_STATUS
            |=> response == 2'h3 && readdata == 32'h00000000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered"); // R12

   // A taken request is answered by waitrequest low for exactly one cycle.
   property p_ack;
      @(posedge clk) disable iff (!rst_n) s_req |=> !waitrequest ##1 waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("bus answer malformed"); // R12

   // A completed mode write with lane 1 lands in the three low control bits.
   property p_wr;
      @(posedge clk) disable iff (!rst_n)
         s_req ##1 s_modeWrDone ##0 byteenable[1]
            |=> modeReg[CMC_BIT_TRACE:CMC_BIT_ARB] == $past(writedata[CMC_BIT_TRACE:CMC_BIT_ARB]);
   endproperty
   a_wr: assert property (p_wr) else $error("write not taken"); // R12

   // A completed mode write with lane 2 lands in the patch bit.
   property p_wrPatch;
      @(posedge clk) disable iff (!rst_n)
         s_req ##1 s_modeWrDone ##0 byteenable[2]
            |=> modeReg[CMC_BIT_PATCH] == $past(writedata[CMC_BIT_PATCH]);
   endproperty
   a_wrPatch: assert property (p_wrPatch) else $error("patch write not taken"); // R12
endmodule : cmc_mode_ctrl
`default_nettype wire
